//--- core/reset_source_combiner.sv
// reset source combiner: merges all reset sources into the master reset and keeps cause flags
// assumes rstn is the power-on reset; pin and brown-out inputs are asynchronous levels
module reset_source_combiner (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic masterClearPinN,
  input wire logic brownoutDetect,
  input rsc_pkg::core_src_t coreSrc,
  input rsc_pkg::core_evt_t coreEvt,
  input wire logic fuseWatchdogForce,
  input rsc_pkg::axi_req_t axiReq,
  output rsc_pkg::axi_rsp_t axiRsp,
  output logic masterResetSignal,
  output logic watchdogEnable,
  output logic regulatorKeepActive
);
  import rsc_pkg::*;

  localparam int RST_CYC_I = RST_CYC;

  typedef struct packed {
    logic [15:0] cause;
    logic [CNT_W-1:0] holdCnt;
    logic mrst;
    logic wdEn;
    logic vregOn;
  } comb_state_t;

  comb_state_t s;
  comb_state_t n;

  logic pinSyncN;
  logic brownSync;
  logic holdReq;
  logic wrCause;
  logic [15:0] wrData;
  logic [1:0] wrStrb;
  logic [15:0] statusVal;

  // ************************************************************
  // pin and brown-out synchronisers
  // ************************************************************
  rsc_sync #(
    .W(1),
    .RST_VAL(1'b1)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .din(masterClearPinN),
    .dout(pinSyncN)
  );

  rsc_sync #(
    .W(1),
    .RST_VAL(1'b0)
  ) u_brown_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .din(brownoutDetect),
    .dout(brownSync)
  );

  // ************************************************************
  // register bus
  // ************************************************************
  assign statusVal = {13'h0000, s.vregOn, s.wdEn, s.mrst};

  rsc_axi_slave u_axi (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .axiReq(axiReq),
    .axiRsp(axiRsp),
    .causeVal(s.cause),
    .statusVal(statusVal),
    .wrCause(wrCause),
    .wrData(wrData),
    .wrStrb(wrStrb)
  );

  // ************************************************************
  // source combination and cause flags
  // ************************************************************
  // power-on is rstn itself; every other source holds the master reset
  assign holdReq = !pinSyncN || brownSync || (|coreSrc);

  always_comb
  begin
    n = s;
    // software write, byte lanes, unimplemented bits stay zero
    if (wrCause)
    begin
      if (wrStrb[0])
        n.cause[7:0] = wrData[7:0];
      if (wrStrb[1])
        n.cause[15:8] = wrData[15:8];
      n.cause = n.cause & CAUSE_WR_MASK;
    end
    if (coreEvt.watchdogClearInstr || coreEvt.powerSaveInstr)
      n.cause[B_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
    // hardware sets come last so they beat the write
    if (coreSrc.trapConflict)
      n.cause[B_TRAP] = 1'b1;
    if (coreSrc.illegalOp || coreSrc.uninitWreg)
      n.cause[B_BADOP] = 1'b1;
    if (coreSrc.cfgMismatch)
      n.cause[B_CFGMIS] = 1'b1;
    if (!pinSyncN)
      n.cause[B_PIN] = 1'b1;
    if (coreSrc.softReset)
      n.cause[B_SOFT] = 1'b1;
    if (coreSrc.wdtTimeout)
      n.cause[B_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
    if (coreEvt.powerSaveInstr && !coreEvt.powerSaveOperand)
      n.cause[B_SLEEP] = 1'b1;
    if (coreEvt.powerSaveInstr && coreEvt.powerSaveOperand)
      n.cause[B_IDLE] = 1'b1;
    if (brownSync)
      n.cause[B_BROWN] = 1'b1;
    // hold timer: restarts while any source is active
    if (holdReq)
    begin
      n.holdCnt = RST_HOLD;
      n.mrst = 1'b1;
    end
    else if (s.holdCnt != '0)
      n.holdCnt = CNT_W'(s.holdCnt - 1'b1);
    else
      n.mrst = 1'b0;
    n.wdEn = n.cause[B_WDEN] || fuseWatchdogForce;
    n.vregOn = n.cause[B_VREG];
  end

  // cause flags and controls only see power-on; master reset leaves them
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      s.cause <= CAUSE_POR_VAL;
      s.holdCnt <= POR_HOLD;
      s.mrst <= 1'b1;
      s.wdEn <= 1'b0;
      s.vregOn <= 1'b0;
    end
    else
      s <= n;
  end

  assign masterResetSignal = s.mrst;
  assign watchdogEnable = s.wdEn;
  assign regulatorKeepActive = s.vregOn;

  // ************************************************************
  // checks
  // ************************************************************
  // cycles spent in master reset since the last active source
  logic [CNT_W:0] relCnt;

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      relCnt <= '0;
    else if (holdReq || !s.mrst)
      relCnt <= '0;
    else
      relCnt <= (CNT_W+1)'(relCnt + 1'b1);
  end

  property p_src_rst;
    @(posedge clk_sys) disable iff (!rstn)
    holdReq |=> masterResetSignal;
  endproperty
  a_src_rst: assert property (p_src_rst) else $error("source without master reset");

  property p_hold_time;
    @(posedge clk_sys) disable iff (!rstn)
    $fell(masterResetSignal) |-> $past(relCnt) >= RST_CYC_I;
  endproperty
  a_hold_time: assert property (p_hold_time) else $error("master reset released early");

  property p_por_hold;
    @(posedge clk_sys) disable iff (!rstn)
    $rose(rstn) |-> masterResetSignal ##1 masterResetSignal[*8];
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("power-on hold missing");

  property p_por_val;
    @(posedge clk_sys) disable iff (!rstn)
    $rose(rstn) |-> s.cause == CAUSE_POR_VAL;
  endproperty
  a_por_val: assert property (p_por_val) else $error("power-on cause value wrong");

  property p_pin_flag;
    @(posedge clk_sys) disable iff (!rstn)
    !pinSyncN |=> s.cause[B_PIN] && masterResetSignal;
  endproperty
  a_pin_flag: assert property (p_pin_flag) else $error("pin flag not set");

  property p_trap_flag;
    @(posedge clk_sys) disable iff (!rstn)
    coreSrc.trapConflict |=> s.cause[B_TRAP];
  endproperty
  a_trap_flag: assert property (p_trap_flag) else $error("trap flag not set");

  property p_badop_flag;
    @(posedge clk_sys) disable iff (!rstn)
    (coreSrc.illegalOp || coreSrc.uninitWreg) |=> s.cause[B_BADOP];
  endproperty
  a_badop_flag: assert property (p_badop_flag) else $error("bad opcode flag not set");

  property p_watchdog_timeout_flag_clr;
    @(posedge clk_sys) disable iff (!rstn)
    (coreEvt.watchdogClearInstr && !coreSrc.wdtTimeout) |=> !s.cause[B_WATCHDOG_TIMEOUT_FLAG];
  endproperty
  a_watchdog_timeout_flag_clr: assert property (p_watchdog_timeout_flag_clr) else $error("watchdog flag not cleared");

  property p_sleep_flag;
    @(posedge clk_sys) disable iff (!rstn)
    (coreEvt.powerSaveInstr && !coreEvt.powerSaveOperand) |=> s.cause[B_SLEEP];
  endproperty
  a_sleep_flag: assert property (p_sleep_flag) else $error("sleep flag not set");

  property p_set_wins;
    @(posedge clk_sys) disable iff (!rstn)
    (wrCause && wrStrb[1] && !wrData[B_CFGMIS] && coreSrc.cfgMismatch) |=> s.cause[B_CFGMIS];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("write beat hardware set");

  property p_wd_force;
    @(posedge clk_sys) disable iff (!rstn)
    fuseWatchdogForce |=> watchdogEnable;
  endproperty
  a_wd_force: assert property (p_wd_force) else $error("fuse did not force watchdog");

  property p_vreg_wr;
    @(posedge clk_sys) disable iff (!rstn)
    (wrCause && wrStrb[1]) |=> ##1 regulatorKeepActive == $past(wrData[B_VREG], 2);
  endproperty
  a_vreg_wr: assert property (p_vreg_wr) else $error("regulator control not written");

  property p_brown_flag;
    @(posedge clk_sys) disable iff (!rstn)
    brownSync |=> s.cause[B_BROWN] && masterResetSignal;
  endproperty
  a_brown_flag: assert property (p_brown_flag) else $error("brown-out flag not set");

  property p_wr_no_rst;
    @(posedge clk_sys) disable iff (!rstn)
    (wrCause && !holdReq && !masterResetSignal) |=> !masterResetSignal;
  endproperty
  a_wr_no_rst: assert property (p_wr_no_rst) else $error("write caused a reset");

  property p_cfg_flag;
    @(posedge clk_sys) disable iff (!rstn)
    coreSrc.cfgMismatch |=> s.cause[B_CFGMIS];
  endproperty
  a_cfg_flag: assert property (p_cfg_flag) else $error("mismatch flag not set");

  property p_cfg_keep;
    @(posedge clk_sys) disable iff (!rstn)
    (s.cause[B_CFGMIS] && !wrCause) |=> s.cause[B_CFGMIS];
  endproperty
  a_cfg_keep: assert property (p_cfg_keep) else $error("mismatch flag lost");

  property p_pin_keep;
    @(posedge clk_sys) disable iff (!rstn)
    (s.cause[B_PIN] && !wrCause) |=> s.cause[B_PIN];
  endproperty
  a_pin_keep: assert property (p_pin_keep) else $error("pin flag lost");

  property p_soft_flag;
    @(posedge clk_sys) disable iff (!rstn)
    coreSrc.softReset |=> s.cause[B_SOFT] && masterResetSignal;
  endproperty
  a_soft_flag: assert property (p_soft_flag) else $error("soft reset flag not set");

  property p_watchdog_timeout_flag_flag;
    @(posedge clk_sys) disable iff (!rstn)
    coreSrc.wdtTimeout |=> s.cause[B_WATCHDOG_TIMEOUT_FLAG];
  endproperty
  a_watchdog_timeout_flag_flag: assert property (p_watchdog_timeout_flag_flag) else $error("watchdog flag not set");

  property p_ps_watchdog_timeout_flag_clr;
    @(posedge clk_sys) disable iff (!rstn)
    (coreEvt.powerSaveInstr && !coreSrc.wdtTimeout) |=> !s.cause[B_WATCHDOG_TIMEOUT_FLAG];
  endproperty
  a_ps_watchdog_timeout_flag_clr: assert property (p_ps_watchdog_timeout_flag_clr) else $error("power-save kept watchdog flag");

  property p_idle_flag;
    @(posedge clk_sys) disable iff (!rstn)
    (coreEvt.powerSaveInstr && coreEvt.powerSaveOperand) |=> s.cause[B_IDLE];
  endproperty
  a_idle_flag: assert property (p_idle_flag) else $error("idle flag not set");

  property p_por_keep;
    @(posedge clk_sys) disable iff (!rstn)
    (s.cause[B_POR] && !wrCause) |=> s.cause[B_POR];
  endproperty
  a_por_keep: assert property (p_por_keep) else $error("power-on flag lost");

  property p_wd_soft;
    @(posedge clk_sys) disable iff (!rstn)
    !fuseWatchdogForce |=> watchdogEnable == s.cause[B_WDEN];
  endproperty
  a_wd_soft: assert property (p_wd_soft) else $error("watchdog enable not from flag");

  property p_hold_load;
    @(posedge clk_sys) disable iff (!rstn)
    holdReq |=> s.holdCnt == RST_HOLD;
  endproperty
  a_hold_load: assert property (p_hold_load) else $error("state reset time not loaded");

  property p_hold_mrst;
    @(posedge clk_sys) disable iff (!rstn)
    (s.holdCnt != '0) |-> masterResetSignal;
  endproperty
  a_hold_mrst: assert property (p_hold_mrst) else $error("master reset low while holding");

  property p_mrst_release;
    @(posedge clk_sys) disable iff (!rstn)
    (!holdReq && s.holdCnt == '0 && masterResetSignal) |=> !masterResetSignal;
  endproperty
  a_mrst_release: assert property (p_mrst_release) else $error("master reset not released");

  property p_por_ctl;
    @(posedge clk_sys) disable iff (!rstn)
    $rose(rstn) |-> !watchdogEnable && !regulatorKeepActive && s.holdCnt == POR_HOLD;
  endproperty
  a_por_ctl: assert property (p_por_ctl) else $error("power-on controls wrong");

endmodule : reset_source_combiner

//--- core/rsc_pkg.sv
// package: constants, field positions and carrier types of the reset source combiner
// assumes a 40 MHz system clock and an AXI4-Lite register bus with 32-bit data
package rsc_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_POR_NS = 10000;
  localparam int T_RST_NS = 32000;
  localparam int POR_CYC = (T_POR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CYC = (T_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 11;
  localparam logic [CNT_W-1:0] POR_HOLD = CNT_W'(POR_CYC + RST_CYC);
  localparam logic [CNT_W-1:0] RST_HOLD = CNT_W'(RST_CYC);

  // ************************************************************
  // register map
  // ************************************************************
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] CAUSE_OFF = 12'h000;
  localparam logic [ADDR_W-1:0] STATUS_OFF = 12'h004;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_CAUSE = 2'h1;
  localparam logic [1:0] SEL_STATUS = 2'h2;

  // reset_cause_control fields
  localparam int B_TRAP = 15;
  localparam int B_BADOP = 14;
  localparam int B_CFGMIS = 9;
  localparam int B_VREG = 8;
  localparam int B_PIN = 7;
  localparam int B_SOFT = 6;
  localparam int B_WDEN = 5;
  localparam int B_WATCHDOG_TIMEOUT_FLAG = 4;
  localparam int B_SLEEP = 3;
  localparam int B_IDLE = 2;
  localparam int B_BROWN = 1;
  localparam int B_POR = 0;
  localparam logic [15:0] CAUSE_POR_VAL = 16'h0003;
  localparam logic [15:0] CAUSE_WR_MASK = 16'hC3FF;

  // status register fields
  localparam int ST_MRST = 0;
  localparam int ST_WDEN = 1;
  localparam int ST_VREG = 2;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic trapConflict;
    logic illegalOp;
    logic uninitWreg;
    logic cfgMismatch;
    logic softReset;
    logic wdtTimeout;
  } core_src_t;

  typedef struct packed {
    logic watchdogClearInstr;
    logic powerSaveInstr;
    logic powerSaveOperand;
  } core_evt_t;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_t;

endpackage : rsc_pkg

//--- core/rsc_sync.sv
// two flip-flop synchroniser for pin level inputs
// assumes the inputs are slow levels from outside the clock domain
module rsc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } sync_state_t;

  sync_state_t s;
  sync_state_t n;

  always_comb
  begin
    n.stage1 = din;
    n.stage2 = s.stage1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      s <= {RST_VAL, RST_VAL};
    else
      s <= n;
  end

  assign dout = s.stage2;

endmodule : rsc_sync

//--- core/rsc_axi_slave.sv
// AXI4-Lite slave for the two registers of the reset source combiner
// assumes one write and one read at most under way; unmapped words answer SLVERR
module rsc_axi_slave (
  input wire logic clk_sys,
  input wire logic rstn,
  input rsc_pkg::axi_req_t axiReq,
  output rsc_pkg::axi_rsp_t axiRsp,
  input wire logic [15:0] causeVal,
  input wire logic [15:0] statusVal,
  output logic wrCause,
  output logic [15:0] wrData,
  output logic [1:0] wrStrb
);
  import rsc_pkg::*;

  typedef struct packed {
    logic awHeld;
    logic wHeld;
    logic [ADDR_W-1:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
    axi_rsp_t rsp;
    logic wrCause;
    logic [15:0] wrData;
    logic [1:0] wrStrb;
  } slave_state_t;

  slave_state_t s;
  slave_state_t n;

  // ************************************************************
  // address decode
  // ************************************************************
  function automatic logic [1:0] regSel(input logic [ADDR_W-1:0] a);
    if (a[ADDR_W-1:2] == CAUSE_OFF[ADDR_W-1:2])
      return SEL_CAUSE;
    else if (a[ADDR_W-1:2] == STATUS_OFF[ADDR_W-1:2])
      return SEL_STATUS;
    else
      return SEL_NONE;
  endfunction : regSel

  always_comb
  begin
    n = s;
    n.wrCause = 1'b0;
    if (axiReq.awvalid && s.rsp.awready)
    begin
      n.awHeld = 1'b1;
      n.addr = axiReq.awaddr;
    end
    if (axiReq.wvalid && s.rsp.wready)
    begin
      n.wHeld = 1'b1;
      n.data = axiReq.wdata;
      n.strb = axiReq.wstrb;
    end
    if (s.rsp.bvalid && axiReq.bready)
      n.rsp.bvalid = 1'b0;
    if (s.awHeld && s.wHeld && !s.rsp.bvalid)
    begin
      n.awHeld = 1'b0;
      n.wHeld = 1'b0;
      n.rsp.bvalid = 1'b1;
      n.rsp.bresp = (regSel(s.addr) == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      n.wrCause = (regSel(s.addr) == SEL_CAUSE) && (|s.strb[1:0]);
      n.wrData = s.data[15:0];
      n.wrStrb = s.strb[1:0];
    end
    n.rsp.awready = !n.awHeld && !n.rsp.bvalid;
    n.rsp.wready = !n.wHeld && !n.rsp.bvalid;
    if (s.rsp.rvalid && axiReq.rready)
      n.rsp.rvalid = 1'b0;
    if (axiReq.arvalid && s.rsp.arready)
    begin
      n.rsp.rvalid = 1'b1;
      case (regSel(axiReq.araddr))
        SEL_CAUSE:
        begin
          n.rsp.rdata = {16'h0000, causeVal};
          n.rsp.rresp = RESP_OKAY;
        end
        SEL_STATUS:
        begin
          n.rsp.rdata = {16'h0000, statusVal};
          n.rsp.rresp = RESP_OKAY;
        end
        default:
        begin
          n.rsp.rdata = 32'h00000000;
          n.rsp.rresp = RESP_SLVERR;
        end
      endcase
    end
    n.rsp.arready = !n.rsp.rvalid;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      s <= '0;
    else
      s <= n;
  end

  assign axiRsp = s.rsp;
  assign wrCause = s.wrCause;
  assign wrData = s.wrData;
  assign wrStrb = s.wrStrb;

endmodule : rsc_axi_slave

//--- verification/core_model.sv
// core model: reset sources, pins and core events that feed the reset source combiner
// assumes it is driven from the bench through its tasks, one call at a time
module core_model (
  input wire logic clk_sys,
  output rsc_pkg::core_src_t coreSrc,
  output rsc_pkg::core_evt_t coreEvt,
  output logic masterClearPinN,
  output logic brownoutDetect
);
  timeunit 1ns;
  timeprecision 100ps;
  import rsc_pkg::*;

  initial
  begin
    coreSrc = '0;
    coreEvt = '0;
    masterClearPinN = 1'b1;
    brownoutDetect = 1'b0;
  end

  // ************************************************************
  // source k held for three cycles: 0..5 core, 6 pin, 7 brown-out
  // ************************************************************
  task automatic fire(input int k);
    @(posedge clk_sys);
    if (k < 6) coreSrc <= core_src_t'(6'h20 >> k);
    masterClearPinN <= (k != 6);
    brownoutDetect <= (k == 7);
    repeat (3) @(posedge clk_sys);
    coreSrc <= '0;
    masterClearPinN <= 1'b1;
    brownoutDetect <= 1'b0;
  endtask : fire

  // one-cycle core event pulse
  task automatic evt(input logic clr, input logic ps, input logic op);
    @(posedge clk_sys);
    coreEvt <= {clr, ps, op};
    @(posedge clk_sys);
    coreEvt <= '0;
  endtask : evt
endmodule : core_model

//--- verification/testbench.sv
// testbench: drives the reset source combiner over AXI4-Lite and through the core model
// assumes the package, the design and the core model are compiled before it
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import rsc_pkg::*;

  logic clk_sys, rstn, fuseWatchdogForce;
  logic masterClearPinN, brownoutDetect;
  logic masterResetSignal, watchdogEnable, regulatorKeepActive;
  axi_req_t axiReq;
  axi_rsp_t axiRsp;
  core_src_t coreSrc;
  core_evt_t coreEvt;
  int fails, nChecks, cyc;
  int srcBit [8] = '{B_TRAP, B_BADOP, B_BADOP, B_CFGMIS, B_SOFT, B_WATCHDOG_TIMEOUT_FLAG, B_PIN, B_BROWN};

  reset_source_combiner dut (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .masterClearPinN(masterClearPinN),
    .brownoutDetect(brownoutDetect),
    .coreSrc(coreSrc),
    .coreEvt(coreEvt),
    .fuseWatchdogForce(fuseWatchdogForce),
    .axiReq(axiReq),
    .axiRsp(axiRsp),
    .masterResetSignal(masterResetSignal),
    .watchdogEnable(watchdogEnable),
    .regulatorKeepActive(regulatorKeepActive)
  );

  core_model core (
    .clk_sys(clk_sys),
    .coreSrc(coreSrc),
    .coreEvt(coreEvt),
    .masterClearPinN(masterClearPinN),
    .brownoutDetect(brownoutDetect)
  );

  // ************************************************************
  // clock and timeout
  // ************************************************************
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      fails++;
      final_report();
    end
  end

  // ************************************************************
  // checking and bus tasks
  // ************************************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    nChecks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic rng(input string what, input int lo, input int hi, input int v);
    nChecks++;
    if (v < lo || v > hi)
    begin
      fails++;
      $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, v);
    end
  endtask : rng

  task automatic axi_write(input logic [11:0] a, input logic [15:0] d);
    logic [1:0] er;
    er = (a == CAUSE_OFF || a == STATUS_OFF) ? RESP_OKAY : RESP_SLVERR;
    @(posedge clk_sys);
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr <= a;
    axiReq.wvalid <= 1'b1;
    axiReq.wdata <= {16'h0000, d};
    axiReq.wstrb <= 4'hF;
    axiReq.bready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (axiReq.awvalid && axiRsp.awready) axiReq.awvalid <= 1'b0;
      if (axiReq.wvalid && axiRsp.wready) axiReq.wvalid <= 1'b0;
    end
    while (axiRsp.bvalid !== 1'b1);
    axiReq.bready <= 1'b0;
    chk("write resp", {30'h0, er}, {30'h0, axiRsp.bresp});
  endtask : axi_write

  task automatic expect_rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk_sys);
    axiReq.arvalid <= 1'b1;
    axiReq.araddr <= a;
    axiReq.rready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (axiReq.arvalid && axiRsp.arready) axiReq.arvalid <= 1'b0;
    end
    while (axiRsp.rvalid !== 1'b1);
    axiReq.rready <= 1'b0;
    chk("read data", e, axiRsp.rdata);
    chk("read resp", {30'h0, er}, {30'h0, axiRsp.rresp});
  endtask : expect_rd

  // source k: master reset rises, then falls after the state reset time
  task automatic reset_by(input int k);
    int t0;
    t0 = cyc;
    core.fire(k);
    repeat (2) @(posedge clk_sys);
    chk("master reset raised", 32'h1, {31'h0, masterResetSignal});
    while (masterResetSignal !== 1'b0) @(posedge clk_sys);
    rng("state reset cycles", RST_HOLD, RST_HOLD + 8, cyc - t0);
  endtask : reset_by

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_por;
    int t0;
    rstn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("master reset in por", 32'h1, {31'h0, masterResetSignal});
    rstn <= 1'b1;
    t0 = cyc;
    expect_rd(CAUSE_OFF, 32'h3, RESP_OKAY);
    while (masterResetSignal !== 1'b0) @(posedge clk_sys);
    rng("por hold cycles", POR_HOLD, POR_HOLD + 3, cyc - t0);
    axi_write(CAUSE_OFF, 16'h0000);
  endtask : t_por

  task automatic t_sources;
    for (int k = 0; k < 8; k++)
    begin
      reset_by(k);
      expect_rd(CAUSE_OFF, 32'h1 << srcBit[k], RESP_OKAY);
      axi_write(CAUSE_OFF, 16'h0000);
    end
  endtask : t_sources

  task automatic t_soft_write;
    axi_write(CAUSE_OFF, 16'hFFFF);
    repeat (2) @(posedge clk_sys);
    chk("no reset on write", 32'h0, {31'h0, masterResetSignal});
    chk("watchdog enable", 32'h1, {31'h0, watchdogEnable});
    chk("keep active", 32'h1, {31'h0, regulatorKeepActive});
    expect_rd(CAUSE_OFF, 32'hC3FF, RESP_OKAY);
    expect_rd(STATUS_OFF, 32'h6, RESP_OKAY);
    axi_write(CAUSE_OFF, 16'h0000);
    fuseWatchdogForce <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("fuse force", 32'h1, {31'h0, watchdogEnable});
    chk("keep active off", 32'h0, {31'h0, regulatorKeepActive});
    fuseWatchdogForce <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("watchdog off", 32'h0, {31'h0, watchdogEnable});
    expect_rd(12'h008, 32'h0, RESP_SLVERR);
    axi_write(STATUS_OFF, 16'hFFFF);
    axi_write(12'h00C, 16'hFFFF);
    expect_rd(STATUS_OFF, 32'h0, RESP_OKAY);
  endtask : t_soft_write

  task automatic t_power_save;
    core.evt(1'b0, 1'b1, 1'b0);
    core.evt(1'b0, 1'b1, 1'b1);
    expect_rd(CAUSE_OFF, 32'hC, RESP_OKAY);
    reset_by(5);
    expect_rd(CAUSE_OFF, 32'h1C, RESP_OKAY);
    core.evt(1'b1, 1'b0, 1'b0);
    expect_rd(CAUSE_OFF, 32'hC, RESP_OKAY);
    reset_by(5);
    core.evt(1'b0, 1'b1, 1'b0);
    expect_rd(CAUSE_OFF, 32'hC, RESP_OKAY);
    axi_write(CAUSE_OFF, 16'hC3FC);
  endtask : t_power_save

  // clearing write lands in the same cycle as a mismatch source
  task automatic t_set_wins;
    fork
      core.fire(3);
      axi_write(CAUSE_OFF, 16'h0000);
    join
    while (masterResetSignal !== 1'b0) @(posedge clk_sys);
    expect_rd(CAUSE_OFF, 32'h1 << B_CFGMIS, RESP_OKAY);
    axi_write(CAUSE_OFF, 16'h0000);
  endtask : t_set_wins

  task automatic final_report;
    $display("checks %0d mismatches %0d", nChecks, fails);
    if (fails == 0 && nChecks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  initial
  begin
    rstn = 1'b0;
    fuseWatchdogForce = 1'b0;
    axiReq = '0;
    fails = 0;
    nChecks = 0;
    t_por();
    t_sources();
    t_set_wins();
    t_soft_write();
    t_power_save();
    t_por();
    final_report();
  end
endmodule : testbench
